// ===== design/irq_power_pkg.sv
// constants for the interrupt controller and power-mode block
// **********************************************************************
// Operation
// RL1: no interrupt taken while global enable is low; enabled ones taken when high.
// RL2: enable register holds one enable bit per source, bits 6 to 0.
// RL3: priority register at b8, bit 7 reserved, bits 6..0 per-source level.
// RL4: two priority levels, nested; high level interrupts a low-level routine.
// RL5: each source vectors to its fixed address.
// RL6: same-level ties served ext0, timer2, two-wire, timer0, ext1, timer1, uart.
// RL7: setting power control bit 0 enters idle; cpu halts, peripherals run.
// RL8: timers, uart, two-wire and external interrupts stay active during idle.
// RL9: idle ends on any enabled interrupt request or any reset.
// RL10: idle keeps cpu status, registers and ram unchanged.
// RL11: power-down stops the master oscillator and keeps all state.
// RL12: power-down ends only on reset or an external interrupt request.
// RL13: external wake from power-down needs level-sensitive mode and its enable.
// RL14: waking source holds its pin low until the oscillator is stable.
// RL15: idle drives address latch and program strobe high; port 0 floats; code floats it in idle only with external memory.
// RL16: power-down drives both strobes low; port 0 floats with external memory.
// RL17: power-down bit enters power-down; interrupt exit clears the mode bit.
// RL18: request taken only above the level of any routine in service.
// **********************************************************************
package irq_power_pkg;
   // **********************************************************************
   // register addresses and reset values
   // **********************************************************************
   localparam logic [7:0] irq_enable_addr = 8'ha8;
   localparam logic [7:0] irq_priority_addr = 8'hb8;
   localparam logic [7:0] power_control_addr = 8'h87;
   localparam logic [7:0] irq_enable_reset = 8'h00;
   localparam logic [7:0] irq_priority_reset = 8'h00;
   localparam logic [7:0] power_control_reset = 8'h00;
   localparam logic [7:0] priority_used_mask = 8'h7f; // bit 7 reserved, reads 0
   localparam logic [7:0] power_control_mask = 8'h8f; // bits 6..4 unused, read 0

   // field positions
   localparam int global_enable_bit = 7;
   localparam int idle_bit = 0;
   localparam int power_down_bit = 1;

   // **********************************************************************
   // sources in same-level service order
   // **********************************************************************
   localparam int num_sources = 7;
   typedef logic [2:0] bit_index_type;
   // enable/priority bit of each source, indexed by service order
   localparam bit_index_type source_bit [num_sources] = '{
      3'h0,   // external 0
      3'h5,   // timer 2
      3'h6,   // two-wire port
      3'h1,   // timer 0
      3'h2,   // external 1
      3'h3,   // timer 1
      3'h4};  // uart
   localparam logic [15:0] source_vector [num_sources] = '{
      16'h0003, 16'h002b, 16'h0053, 16'h000b, 16'h0013, 16'h001b, 16'h0023};
   // service-order index of the external interrupts
   localparam int ext0_order = 0;
   localparam int ext1_order = 4;

   typedef enum {
      mode_run,
      mode_idle,
      mode_power_down
   } power_state_type;
endpackage

// ===== design/irq_power_ctrl.sv
// interrupt controller with idle and power-down mode control
module irq_power_ctrl #(
   parameter int vector_width = 16
) (
   input wire logic clk_i,
   input wire logic reset_i,
   // special function register access
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   output logic sfr_hit_o,
   // source request flags, in service order
   input wire logic ext0_request_flag_i,
   input wire logic timer2_overflow_flag_i,
   input wire logic timer2_external_flag_i,
   input wire logic twowire_request_i,
   input wire logic timer0_overflow_flag_i,
   input wire logic ext1_request_flag_i,
   input wire logic timer1_overflow_flag_i,
   input wire logic uart_rx_flag_i,
   input wire logic uart_tx_flag_i,
   // external interrupt pins and their trigger mode
   input wire logic ext0_pin_n_i,
   input wire logic ext1_pin_n_i,
   input wire logic ext0_edge_mode_i,
   input wire logic ext1_edge_mode_i,
   input wire logic ext_memory_i,
   // cpu core handshake
   output logic irq_request_o,
   output logic [vector_width-1:0] irq_vector_o,
   output logic irq_level_o,
   input wire logic irq_ack_i,
   input wire logic irq_return_i,
   // power-mode effects
   output logic cpu_halt_o,
   output logic osc_stop_o,
   output logic ale_force_o,
   output logic ale_level_o,
   output logic prog_store_strobe_force_o,
   output logic prog_store_strobe_level_o,
   output logic port0_float_o,
   output logic port2_address_o
);
   // refuse a vector port too narrow for the addresses, or source tables of another size
   generate
      if (vector_width < 16) begin : g_width_check
         $error("vector_width must hold a 16-bit vector address");
      end
      if (irq_power_pkg::num_sources != 7) begin : g_source_check
         $error("source tables must list seven sources");
      end
   endgenerate

   // **********************************************************************
   // registers
   // **********************************************************************
   logic [7:0] irq_enable_reg_q;
   logic [7:0] irq_priority_reg_q;
   logic [7:0] power_control_reg_q;
   irq_power_pkg::power_state_type mode_q;
   logic in_service_low_q;
   logic in_service_high_q;

   // combinational request decode
   logic [irq_power_pkg::num_sources-1:0] raw_req;
   logic [irq_power_pkg::num_sources-1:0] pend_high;
   logic [irq_power_pkg::num_sources-1:0] pend_low;
   logic enabled_any;
   logic ext_wake;
   logic take_high;
   logic take_low;
   logic [15:0] chosen_vector;
   logic chosen_level;
   logic wr_enable;
   logic wr_priority;
   logic wr_power;

   // decoded register writes
   assign wr_enable = sfr_wr_i && (sfr_addr_i == irq_power_pkg::irq_enable_addr);
   assign wr_priority = sfr_wr_i && (sfr_addr_i == irq_power_pkg::irq_priority_addr);
   assign wr_power = sfr_wr_i && (sfr_addr_i == irq_power_pkg::power_control_addr);

   // request lines in service order; uart and timer 2 each share one vector
   assign raw_req = {uart_rx_flag_i | uart_tx_flag_i,
                     timer1_overflow_flag_i,
                     ext1_request_flag_i,
                     timer0_overflow_flag_i,
                     twowire_request_i,
                     timer2_overflow_flag_i | timer2_external_flag_i,
                     ext0_request_flag_i};

   // **********************************************************************
   // per-source enable and level split
   // **********************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < irq_power_pkg::num_sources; gi++) begin : g_src
         logic en;
         logic hi;
         assign en = raw_req[gi]
                     && irq_enable_reg_q[irq_power_pkg::source_bit[gi]]; // RL2
         assign hi = irq_priority_reg_q[irq_power_pkg::source_bit[gi]]; // RL3
         assign pend_high[gi] = en && hi;
         assign pend_low[gi] = en && !hi;
      end
   endgenerate

   // any individually enabled request while global enable is set, used to end idle
   assign enabled_any = irq_enable_reg_q[irq_power_pkg::global_enable_bit]
                        && ((|pend_high) || (|pend_low)); // RL9

   // level-triggered, enabled external interrupt with pin low wakes power-down
   assign ext_wake = irq_enable_reg_q[irq_power_pkg::global_enable_bit]
      && ((!ext0_edge_mode_i && !ext0_pin_n_i
           && irq_enable_reg_q[irq_power_pkg::source_bit[irq_power_pkg::ext0_order]])
       || (!ext1_edge_mode_i && !ext1_pin_n_i
           && irq_enable_reg_q[irq_power_pkg::source_bit[irq_power_pkg::ext1_order]]));
   // RL12 RL13 RL14

   // **********************************************************************
   // acceptance against routines in service and global enable
   // **********************************************************************
   // high needs only the high level free; low needs both levels free
   assign take_high = irq_enable_reg_q[irq_power_pkg::global_enable_bit] // RL1
                      && (|pend_high) && !in_service_high_q; // RL4 RL18
   assign take_low = irq_enable_reg_q[irq_power_pkg::global_enable_bit] // RL1
                     && !take_high && (|pend_low)
                     && !in_service_high_q && !in_service_low_q; // RL18

   // fixed order within the chosen level: lowest index wins
   always_comb begin
      chosen_vector = 16'h0000;
      chosen_level = take_high;
      for (int i = irq_power_pkg::num_sources - 1; i >= 0; i--) begin
         if (take_high ? pend_high[i] : pend_low[i]) begin
            chosen_vector = irq_power_pkg::source_vector[i]; // RL5 RL6
         end
      end
   end

   // **********************************************************************
   // register writes
   // **********************************************************************
   // enable register, all eight bits writable
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_enable_reg_q <= irq_power_pkg::irq_enable_reset;
      end else if (wr_enable) begin
         irq_enable_reg_q <= sfr_wdata_i; // RL1 RL2
      end
   end

   // priority register, reserved bit stores zero
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_priority_reg_q <= irq_power_pkg::irq_priority_reset;
      end else if (wr_priority) begin
         irq_priority_reg_q <= sfr_wdata_i & irq_power_pkg::priority_used_mask; // RL3
      end
   end

   // power control: software sets mode bits, hardware wake clears them
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         power_control_reg_q <= irq_power_pkg::power_control_reset; // RL9 RL12
      end else if (wr_power) begin
         power_control_reg_q <= sfr_wdata_i & irq_power_pkg::power_control_mask; // RL7 RL17
      end else if ((mode_q == irq_power_pkg::mode_idle && enabled_any)
                   || (mode_q == irq_power_pkg::mode_power_down && ext_wake)) begin
         power_control_reg_q[irq_power_pkg::idle_bit] <= 1'b0; // RL17
         power_control_reg_q[irq_power_pkg::power_down_bit] <= 1'b0;
      end
   end

   // registered read data, unmapped addresses read zero
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sfr_rdata_o <= 8'h00;
         sfr_hit_o <= 1'b0;
      end else begin
         case (sfr_addr_i)
            irq_power_pkg::irq_enable_addr: begin
               sfr_rdata_o <= irq_enable_reg_q;
               sfr_hit_o <= 1'b1;
            end
            irq_power_pkg::irq_priority_addr: begin
               sfr_rdata_o <= irq_priority_reg_q;
               sfr_hit_o <= 1'b1;
            end
            irq_power_pkg::power_control_addr: begin
               sfr_rdata_o <= power_control_reg_q;
               sfr_hit_o <= 1'b1;
            end
            default: begin
               sfr_rdata_o <= 8'h00;
               sfr_hit_o <= 1'b0;
            end
         endcase
      end
   end

   // **********************************************************************
   // power mode state
   // **********************************************************************
   // mode follows the power control bits; power-down wins if both are set
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mode_q <= irq_power_pkg::mode_run;
      end else begin
         case (mode_q)
            irq_power_pkg::mode_run: begin
               if (power_control_reg_q[irq_power_pkg::power_down_bit]) begin
                  mode_q <= irq_power_pkg::mode_power_down; // RL17 RL11
               end else if (power_control_reg_q[irq_power_pkg::idle_bit]) begin
                  mode_q <= irq_power_pkg::mode_idle; // RL7
               end
            end
            irq_power_pkg::mode_idle: begin
               if (enabled_any) begin
                  mode_q <= irq_power_pkg::mode_run; // RL9
               end
            end
            irq_power_pkg::mode_power_down: begin
               if (ext_wake) begin
                  mode_q <= irq_power_pkg::mode_run; // RL12
               end
            end
            default: begin
               mode_q <= irq_power_pkg::mode_run;
            end
         endcase
      end
   end

   // **********************************************************************
   // cpu handshake and in-service levels
   // **********************************************************************
   // request keeps being evaluated while idle; only power-down freezes it
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_request_o <= 1'b0;
         irq_vector_o <= '0;
         irq_level_o <= 1'b0;
      end else if (irq_ack_i && irq_request_o) begin
         irq_request_o <= 1'b0;
      end else if (mode_q != irq_power_pkg::mode_power_down) begin // RL8
         irq_request_o <= take_high || take_low;
         irq_vector_o <= vector_width'(chosen_vector); // RL5
         irq_level_o <= chosen_level; // RL4
      end
   end

   // in-service levels: return pops the highest level, ack pushes the taken one
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         in_service_high_q <= 1'b0;
         in_service_low_q <= 1'b0;
      end else begin
         if (irq_return_i) begin
            if (in_service_high_q) begin
               in_service_high_q <= 1'b0; // RL18
            end else begin
               in_service_low_q <= 1'b0;
            end
         end
         // a take in the same cycle as a return is not lost; the set wins
         if (irq_ack_i && irq_request_o) begin
            if (irq_level_o) begin
               in_service_high_q <= 1'b1; // RL4
            end else begin
               in_service_low_q <= 1'b1;
            end
         end
      end
   end

   // **********************************************************************
   // pin states in idle and power-down
   // **********************************************************************
   // force/level pairs; the port logic outside applies them
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cpu_halt_o <= 1'b0;
         osc_stop_o <= 1'b0;
         ale_force_o <= 1'b0;
         ale_level_o <= 1'b0;
         prog_store_strobe_force_o <= 1'b0;
         prog_store_strobe_level_o <= 1'b0;
         port0_float_o <= 1'b0;
         port2_address_o <= 1'b0;
      end else begin
         // halt keeps cpu state, registers and ram frozen
         cpu_halt_o <= (mode_q != irq_power_pkg::mode_run); // RL10 RL11
         osc_stop_o <= (mode_q == irq_power_pkg::mode_power_down); // RL11
         ale_force_o <= (mode_q != irq_power_pkg::mode_run);
         ale_level_o <= (mode_q == irq_power_pkg::mode_idle); // RL15 RL16
         prog_store_strobe_force_o <= (mode_q != irq_power_pkg::mode_run);
         prog_store_strobe_level_o <= (mode_q == irq_power_pkg::mode_idle); // RL15 RL16
         port0_float_o <= (mode_q != irq_power_pkg::mode_run) && ext_memory_i; // RL15 RL16
         port2_address_o <= (mode_q == irq_power_pkg::mode_idle) && ext_memory_i; // RL15
      end
   end
endmodule // irq_power_ctrl

// ===== verif/irq_power_ctrl_assertions.sv
// port-level checker for the interrupt and power-mode block
module irq_power_checker #(
   parameter int vector_width = 16
) (
   input wire logic clk_i, reset_i, sfr_wr_i,
   input wire logic [7:0] sfr_addr_i, sfr_wdata_i,
   input wire logic ext0_request_flag_i, timer2_overflow_flag_i, timer2_external_flag_i,
   input wire logic twowire_request_i, timer0_overflow_flag_i, ext1_request_flag_i,
   input wire logic timer1_overflow_flag_i, uart_rx_flag_i, uart_tx_flag_i,
   input wire logic ext0_pin_n_i, ext1_pin_n_i, ext0_edge_mode_i, ext1_edge_mode_i,
   input wire logic ext_memory_i, irq_request_o, irq_level_o, cpu_halt_o, osc_stop_o,
   input wire logic [vector_width-1:0] irq_vector_o,
   input wire logic ale_force_o, ale_level_o, prog_store_strobe_force_o,
   input wire logic prog_store_strobe_level_o, port0_float_o, port2_address_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] en_q;
   logic [7:0] pr_q;
   logic [6:0] req;
   logic en_req;
   logic pd_wake;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // shadow copies of the enable and priority registers
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         en_q <= 8'h00;
         pr_q <= 8'h00;
      end else if (sfr_wr_i && sfr_addr_i == 8'ha8) begin
         en_q <= sfr_wdata_i;
      end else if (sfr_wr_i && sfr_addr_i == 8'hb8) begin
         pr_q <= sfr_wdata_i;
      end
   end
   // request flags in enable-bit order, and the two wake causes
   assign req = {twowire_request_i, timer2_overflow_flag_i | timer2_external_flag_i,
      uart_rx_flag_i | uart_tx_flag_i, timer1_overflow_flag_i, ext1_request_flag_i,
      timer0_overflow_flag_i, ext0_request_flag_i};
   assign en_req = en_q[7] && |(req & en_q[6:0]);
   assign pd_wake = en_q[7] && ((!ext0_pin_n_i && !ext0_edge_mode_i && en_q[0])
      || (!ext1_pin_n_i && !ext1_edge_mode_i && en_q[2]));
   a_no_global_req: assert property ($rose(irq_request_o) |-> $past(en_q[7]))
      else $error("request raised with global enable off");
   a_ext0_wins: assert property (
      $rose(irq_request_o) && $past(ext0_request_flag_i && en_q[0] && pr_q[0])
      |-> irq_vector_o == 16'h0003 && irq_level_o)
      else $error("high external 0 request not chosen first");
   a_idle_pins: assert property (
      cpu_halt_o && !osc_stop_o |-> ale_force_o && ale_level_o
      && prog_store_strobe_force_o && prog_store_strobe_level_o)
      else $error("idle strobe levels wrong");
   a_pd_pins: assert property (
      osc_stop_o |-> cpu_halt_o && ale_force_o && !ale_level_o
      && prog_store_strobe_force_o && !prog_store_strobe_level_o && !port2_address_o)
      else $error("power-down pin states wrong");
   a_pd_frozen: assert property (osc_stop_o |-> !$rose(irq_request_o))
      else $error("request raised during power-down");
   a_float_mem: assert property (port0_float_o == (cpu_halt_o && $past(ext_memory_i)))
      else $error("port 0 float state wrong");
   a_pd_wake_src: assert property ($fell(osc_stop_o) |-> $past(pd_wake, 2))
      else $error("power-down left without a legal wake");
   a_idle_wake_src: assert property (
      $fell(cpu_halt_o) && !$past(osc_stop_o) |-> $past(en_req, 2))
      else $error("idle left without an enabled request");
   a_idle_entry: assert property (
      (sfr_wr_i && sfr_addr_i == 8'h87 && sfr_wdata_i[1:0] == 2'h1 ##1 (!en_req) [*2])
      |=> cpu_halt_o && !osc_stop_o)
      else $error("idle not entered after mode write");
   a_pd_entry: assert property (
      (sfr_wr_i && sfr_addr_i == 8'h87 && sfr_wdata_i[1] ##1 (!pd_wake) [*2]) |=> osc_stop_o)
      else $error("power-down not entered after mode write");
endmodule // irq_power_checker

bind irq_power_ctrl irq_power_checker #(.vector_width(vector_width)) i_chk (.*);

// ===== verif/cpu_core_model.sv
// behavioural cpu core taking interrupt requests and returning from them
module cpu_core_model (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic irq_request_i,
   input wire logic [15:0] irq_vector_i,
   input wire logic [3:0] ack_delay_i,
   input wire logic ret_cmd_i,
   output logic irq_ack_o,
   output logic irq_return_o,
   output logic taken_o,
   output logic [15:0] taken_vector_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_q;
   // ack a standing request after the chosen delay, one cycle, never twice in a row
   always_ff @(posedge clk_i) begin
      irq_ack_o <= 1'b0;
      taken_o <= 1'b0;
      irq_return_o <= ret_cmd_i && !reset_i;
      if (reset_i || !irq_request_i || irq_ack_o) begin
         wait_q <= 4'h0;
      end else if (wait_q >= ack_delay_i) begin
         irq_ack_o <= 1'b1;
         taken_o <= 1'b1;
         taken_vector_o <= irq_vector_i;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule // cpu_core_model

// ===== verif/irq_power_ctrl_tb_top.sv
// self-checking bench for the interrupt and power-mode block
module interrupt_and_power_modes_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_count++; \
   $display("MISMATCH %s exp %h got %h", n, e, a); end end
   logic clk_i = 1'b0, reset_i = 1'b1, sfr_wr_i = 1'b0, alt = 1'b0;
   logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
   logic [6:0] flg = 7'h00;
   logic ext0_pin_n_i = 1'b1, ext1_pin_n_i = 1'b1, ext0_edge_mode_i = 1'b0;
   logic ext1_edge_mode_i = 1'b1, ext_memory_i = 1'b1, irq_ack_i, irq_return_i;
   logic sfr_hit_o, irq_request_o, irq_level_o, cpu_halt_o, osc_stop_o, ale_force_o;
   logic ale_level_o, prog_store_strobe_force_o, prog_store_strobe_level_o;
   logic port0_float_o, port2_address_o, taken, ret_cmd = 1'b0, look_q = 1'b0, pins = 1'b0;
   logic [15:0] irq_vector_o, taken_vector, exp_v, obs, v;
   logic [3:0] ack_delay = 4'h0;
   logic [15:0] exp_q [$];
   int err_count = 0, compares = 0, seed = 32'h0d55715f;
   // flags in service order; alt picks the second flag of the shared vectors
   wire ext0_request_flag_i = flg[0];
   wire timer2_overflow_flag_i = flg[1] && !alt;
   wire timer2_external_flag_i = flg[1] && alt;
   wire twowire_request_i = flg[2];
   wire timer0_overflow_flag_i = flg[3];
   wire ext1_request_flag_i = flg[4];
   wire timer1_overflow_flag_i = flg[5];
   wire uart_rx_flag_i = flg[6] && !alt;
   wire uart_tx_flag_i = flg[6] && alt;
   assign obs = pins ? {8'h00, cpu_halt_o, osc_stop_o, ale_force_o, ale_level_o,
      prog_store_strobe_force_o, prog_store_strobe_level_o, port0_float_o, port2_address_o}
      : {7'h00, sfr_hit_o, sfr_rdata_o};
   irq_power_ctrl i_dut (.*);
   cpu_core_model i_cpu (.clk_i(clk_i), .reset_i(reset_i), .irq_request_i(irq_request_o),
      .irq_vector_i(irq_vector_o), .ack_delay_i(ack_delay), .ret_cmd_i(ret_cmd),
      .irq_ack_o(irq_ack_i), .irq_return_o(irq_return_i), .taken_o(taken),
      .taken_vector_o(taken_vector));
   always #2.5 clk_i = ~clk_i;
   // monitor: each taken vector or strobed look is matched to the oldest note
   always @(posedge clk_i) begin
      if (look_q || taken) begin
         exp_v = 16'hxxxx;
         if (exp_q.size() > 0) exp_v = exp_q.pop_front();
         `CHK("result", exp_v, (taken ? taken_vector : obs))
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'b1;
      @(posedge clk_i);
      sfr_wr_i <= 1'b0;
   endtask
   task automatic look(input logic p, input logic [7:0] a, input logic [8:0] e);
      @(posedge clk_i);
      sfr_addr_i <= a;
      pins <= p;
      exp_q.push_back({7'h00, e});
      @(posedge clk_i);
      look_q <= 1'b1;
      @(posedge clk_i);
      look_q <= 1'b0;
   endtask
   task automatic take();
      int n = 0;
      @(posedge clk_i);
      while (!taken && n < 60) begin
         @(posedge clk_i);
         n++;
      end
      if (!taken) begin
         err_count++;
         $display("MISMATCH take exp 1 got 0");
      end
   endtask
   task automatic retire(input int i);
      flg[i] <= 1'b0;
      ret_cmd <= 1'b1;
      @(posedge clk_i);
      ret_cmd <= 1'b0;
   endtask
   task automatic final_report();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #50us;
      err_count++;
      $display("MISMATCH watchdog exp done got hang");
      final_report();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      look(0, 8'ha8, 9'h100);
      look(0, 8'hb8, 9'h100);
      look(0, 8'h87, 9'h100);
      look(0, 8'h90, 9'h000);
      repeat (4) begin
         v = 16'($random(seed));
         wr(8'ha8, v[7:0]);
         wr(8'hb8, v[15:8]);
         look(0, 8'ha8, {1'b1, v[7:0]});
         look(0, 8'hb8, {2'b10, v[14:8]});
      end
      // every source pending at one level with global enable off, then on
      alt <= v[0];
      wr(8'hb8, 8'h00);
      wr(8'ha8, 8'h7f);
      flg <= 7'h7f;
      repeat (10) @(posedge clk_i);
      for (int i = 0; i < 7; i++) exp_q.push_back(irq_power_pkg::source_vector[i]);
      wr(8'ha8, 8'hff);
      for (int i = 0; i < 7; i++) begin
         ack_delay <= 4'(i * 2);
         take();
         retire(i);
      end
      // high external 1 preempts low timer 1; low timer 0 waits for both returns
      wr(8'hb8, 8'h04);
      exp_q.push_back(16'h001b);
      exp_q.push_back(16'h0013);
      exp_q.push_back(16'h000b);
      flg <= 7'h20;
      take();
      flg <= 7'h38;
      take();
      retire(4);
      repeat (8) @(posedge clk_i);
      `CHK("held", 1, exp_q.size())
      retire(5);
      take();
      retire(3);
      // idle, woken by a high-level external 0 request
      wr(8'hb8, 8'h01);
      wr(8'ha8, 8'h81);
      wr(8'h87, 8'h01);
      look(1, 8'h87, 9'h0bf);
      exp_q.push_back(16'h0003);
      flg <= 7'h01;
      take();
      retire(0);
      look(1, 8'h87, 9'h000);
      look(0, 8'h87, 9'h100);
      // power-down: timer and edge-mode pin ignored, level pin wakes
      wr(8'ha8, 8'h8f);
      wr(8'h87, 8'h02);
      ext1_pin_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      flg <= 7'h08; // timer pends only once power-down holds
      repeat (8) @(posedge clk_i);
      look(1, 8'h87, 9'h0ea);
      ext1_pin_n_i <= 1'b1;
      exp_q.push_back(16'h000b);
      ext0_pin_n_i <= 1'b0;
      take();
      ext0_pin_n_i <= 1'b1;
      retire(3);
      look(1, 8'h87, 9'h000);
      // reset in mid-run clears the enable register
      reset_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      look(0, 8'ha8, 9'h100);
      final_report();
   end
endmodule // interrupt_and_power_modes_tb_top
